//--- core/adc_seq_defines.svh
// Purpose: Offsets, field positions, reset values and timing figures of the sequencer
// Assumes: 20 MHz system clock
// Notes: Definitions only
`ifndef ADC_SEQ_DEFINES_SVH
`define ADC_SEQ_DEFINES_SVH

// Timing figures in nanoseconds
`define CLK_PERIOD_NS 50
`define CORE_PERIOD_NS 750
`define SYNC_MAX_NS 30000
`define DELAY_STEP_NS 40000

// Register byte offsets
`define OFF_CTRL 8'h00
`define OFF_SELECT 8'h04
`define OFF_STATUS 8'h08
`define OFF_MASK 8'h0c
`define OFF_RESULT0 8'h10
`define OFF_RESULT3 8'h1c

// Control register fields
`define CTRL_ON 0
`define CTRL_GO 1
`define CTRL_CONT 2
`define CTRL_FREEZE 3
`define CTRL_LAST_LO 4
`define CTRL_DLY1_LO 8
`define CTRL_DLY2_LO 12
`define CTRL_DLY3_LO 16
`define CTRL_WMASK 32'h000f_ff7f

// Status and mask fields
`define STAT_DONE 0
`define STAT_BUSY 1
`define STAT_CAL 2
`define MASK_DONE 0

// Reset values
`define CTRL_RESET 32'h0000_0000
`define SELECT_RESET 32'h0000_0000
`define MASK_RESET 1'h0

// Bus answers
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

// Input scaling
`define CH_COIN_CELL 4'h8
`define SCALE_X1 2'h0
`define SCALE_X2_3 2'h1

`endif

//--- core/adc_seq_pkg.sv
// Purpose: Types shared by the sequencer and its converter core
// Assumes: Constants live in adc_seq_defines.svh
// Notes: Structs carry grouped signals
package adc_seq_pkg;

    // Requests to the analog converter core
    typedef struct packed {
        logic power_on;
        logic calibrate;
        logic start;
        logic [1:0] scale;
        logic [3:0] channel;
    } core_req_t;

    // Answers from the analog converter core
    typedef struct packed {
        logic done;
        logic [9:0] code;
    } core_rsp_t;

    // Sequencer states
    typedef enum logic [3:0] {
        S_CAL_START, S_CAL_WAIT, S_IDLE, S_SYNC, S_FIRST,
        S_CONV, S_WAIT, S_GAP, S_LOOP
    } seq_state_t;

endpackage

//--- core/sync_two_ff.sv
// Purpose: Two flip-flop synchroniser for a vector from outside the clock domain
// Assumes: Bits are stable around the edge that the consumer acts on
// Notes: First stage feeds only the second stage
module sync_two_ff #(
    parameter int W = 1
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic reset_n,
    // Data
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] sync_out
);
    logic [W-1:0] meta_reg;

    // Two stages, cleared under reset
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            meta_reg <= '0;
            sync_out <= '0;
        end else begin
            meta_reg <= async_in;
            sync_out <= meta_reg;
        end
    end
endmodule

//--- core/delay_timer.sv
// Purpose: Down counter for the programmable waits
// Assumes: Load and count share the system clock
// Notes: A load of zero expires on the next cycle
module delay_timer #(
    parameter int W = 14
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic reset_n,
    // Control
    input wire logic load,
    input wire logic [W-1:0] value,
    output logic expired
);
    logic [W-1:0] count_reg;

    // Load wins over counting
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            count_reg <= '0;
        end else if (load) begin
            count_reg <= value;
        end else if (count_reg != '0) begin
            count_reg <= count_reg - 1'b1;
        end
    end

    // Expiry ignores load, so a caller may reload on expiry without a combinational loop
    assign expired = (count_reg == '0);
endmodule

//--- core/adc_conversion_sequencer.sv
// Purpose: Sequencer for a 10-bit 16-channel converter, AXI4-Lite registers
// Assumes: 20 MHz sys_clk; core answers come from outside this clock domain
// Notes on behaviour
// - 10-bit codes, core paced at about 1.33 MHz
// - Sixteen channels, four-bit select equals number
// - Coin cell channel eight scaled by two thirds
// - Out-of-range inputs give full scale or zero
// - Finished sequence raises done event
// - Mask bit keeps done off interrupt output
// - Converter off means low power outside calibration, no conversions
// - Enable first, then start begins one series
// - Calibration runs by itself after power-up
// - Sync wait then first delay before conversion
// - Second delay field spaces conversions, 0-600us
// - Third delay after last, only when looping
// - Delay code times 40us, all reset zero
// - At most eight conversions per series
// - Slot selects channel, result stored per slot
// - Slots zero up to last slot field
// - Continuous bit loops; resets low
// - Freeze bit stops result updates while set in continuous mode
// - Results readable in four result registers
`include "adc_seq_defines.svh"
module adc_conversion_sequencer #(
    parameter int ADDR_W = 8,
    parameter int SLOTS = 8
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic reset_n,
    // AXI4-Lite write channels
    input wire logic [ADDR_W-1:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    // AXI4-Lite read channels
    input wire logic [ADDR_W-1:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    // Converter core
    output adc_seq_pkg::core_req_t core_req,
    output logic core_clk_en,
    input wire adc_seq_pkg::core_rsp_t core_rsp,
    // Interrupt
    output logic done_irq
);
    import adc_seq_pkg::*;

    localparam int SYNC_CYC = `SYNC_MAX_NS / `CLK_PERIOD_NS;
    localparam int STEP_CYC = (`DELAY_STEP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
    localparam int CORE_DIV = `CORE_PERIOD_NS / `CLK_PERIOD_NS;
    localparam int TW = 14;

    logic [31:0] ctrl_reg;
    logic [31:0] select_reg;
    logic mask_reg;
    logic done_flag_reg;
    logic calibrated_reg;
    logic [9:0] result_reg [SLOTS];
    logic [ADDR_W-1:0] aw_addr_reg;
    logic [31:0] w_data_reg;
    logic [3:0] w_strb_reg;
    logic [2:0] slot_reg;
    logic [2:0] slot_next;
    logic [4:0] div_reg;
    logic done_prev_reg;
    seq_state_t state_reg;
    seq_state_t state_next;
    core_rsp_t rsp_sync;
    logic done_rise;
    logic wr_fire;
    logic go_take;
    logic seq_end;
    logic store_ok;
    logic tmr_load;
    logic [TW-1:0] tmr_value;
    logic tmr_expired;
    logic [3:0] sel_ch;
    logic [2:0] last_slot;

    // Byte-lane merge for writable registers
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                          input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[i*8 +: 8] = d[i*8 +: 8];
            end
        end
        return r;
    endfunction

    // Core answers cross in through two flops
    sync_two_ff #(.W(11)) u_rsp_sync (
        .sys_clk(sys_clk),
        .reset_n(reset_n),
        .async_in(core_rsp),
        .sync_out(rsp_sync)
    );

    // Shared wait counter for sync and programmable delays
    delay_timer #(.W(TW)) u_timer (
        .sys_clk(sys_clk),
        .reset_n(reset_n),
        .load(tmr_load),
        .value(tmr_value),
        .expired(tmr_expired)
    );

    assign last_slot = ctrl_reg[`CTRL_LAST_LO +: 3];
    assign sel_ch = select_reg[slot_reg*4 +: 4];
    assign wr_fire = !awready && !wready && !bvalid;
    assign done_rise = rsp_sync.done && !done_prev_reg;
    // Start only counts from idle with the converter already on
    assign go_take = ctrl_reg[`CTRL_GO] && ctrl_reg[`CTRL_ON] && state_reg == S_IDLE;
    assign seq_end = state_reg == S_WAIT && done_rise && slot_reg == last_slot;
    assign store_ok = !(ctrl_reg[`CTRL_CONT] && ctrl_reg[`CTRL_FREEZE]);

    // Core pacing divider gives the slow clock enable
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            div_reg <= '0;
            core_clk_en <= 1'b0;
        end else begin
            core_clk_en <= (div_reg == 5'(CORE_DIV - 1));
            div_reg <= (div_reg == 5'(CORE_DIV - 1)) ? '0 : div_reg + 5'h1;
        end
    end

    // Write address and data are taken in either order
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            awready <= 1'b1;
            wready <= 1'b1;
            bvalid <= 1'b0;
            bresp <= `RESP_OKAY;
            aw_addr_reg <= '0;
            w_data_reg <= '0;
            w_strb_reg <= '0;
        end else begin
            if (awvalid && awready) begin
                awready <= 1'b0;
                aw_addr_reg <= awaddr;
            end
            if (wvalid && wready) begin
                wready <= 1'b0;
                w_data_reg <= wdata;
                w_strb_reg <= wstrb;
            end
            if (wr_fire) begin
                bvalid <= 1'b1;
                bresp <= (aw_addr_reg > `OFF_RESULT3 || aw_addr_reg[1:0] != 2'h0) ?
                         `RESP_SLVERR : `RESP_OKAY;
            end else if (bvalid && bready) begin
                bvalid <= 1'b0;
                awready <= 1'b1;
                wready <= 1'b1;
            end
        end
    end

    // Control register; start clears itself once seen
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            ctrl_reg <= `CTRL_RESET;
        end else if (wr_fire && aw_addr_reg == `OFF_CTRL) begin
            ctrl_reg <= merge(ctrl_reg, w_data_reg, w_strb_reg) & `CTRL_WMASK;
        end else begin
            ctrl_reg[`CTRL_GO] <= 1'b0;
        end
    end

    // Slot channel selects and done mask
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            select_reg <= `SELECT_RESET;
            mask_reg <= `MASK_RESET;
        end else if (wr_fire) begin
            if (aw_addr_reg == `OFF_SELECT) begin
                select_reg <= merge(select_reg, w_data_reg, w_strb_reg);
            end
            if (aw_addr_reg == `OFF_MASK && w_strb_reg[0]) begin
                mask_reg <= w_data_reg[`MASK_DONE];
            end
        end
    end

    // Done flag: set wins over a write-one clear
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            done_flag_reg <= 1'b0;
        end else if (seq_end) begin
            done_flag_reg <= 1'b1;
        end else if (wr_fire && aw_addr_reg == `OFF_STATUS && w_strb_reg[0]
                     && w_data_reg[`STAT_DONE]) begin
            done_flag_reg <= 1'b0;
        end
    end

    // Interrupt output follows the flag unless masked
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            done_irq <= 1'b0;
        end else begin
            done_irq <= done_flag_reg && !mask_reg;
        end
    end

    // Read channel; one read at a time
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            arready <= 1'b1;
            rvalid <= 1'b0;
            rdata <= '0;
            rresp <= `RESP_OKAY;
        end else if (arvalid && arready) begin
            arready <= 1'b0;
            rvalid <= 1'b1;
            rresp <= `RESP_OKAY;
            rdata <= '0;
            case (araddr)
                `OFF_CTRL: rdata <= ctrl_reg;
                `OFF_SELECT: rdata <= select_reg;
                `OFF_STATUS: rdata <= {29'h0, calibrated_reg, state_reg != S_IDLE,
                                       done_flag_reg};
                `OFF_MASK: rdata <= {31'h0, mask_reg};
                default: begin
                    // Two slot results per word, even slot low
                    if (araddr >= `OFF_RESULT0 && araddr <= `OFF_RESULT3
                        && araddr[1:0] == 2'h0) begin
                        rdata <= {6'h0, result_reg[araddr[3:2]*2 + 1],
                                  6'h0, result_reg[araddr[3:2]*2]};
                    end else begin
                        rresp <= `RESP_SLVERR;
                    end
                end
            endcase
        end else if (rvalid && rready) begin
            rvalid <= 1'b0;
            arready <= 1'b1;
        end
    end

    // Sequencer next state and timer loads
    always_comb begin
        state_next = state_reg;
        slot_next = slot_reg;
        tmr_load = 1'b0;
        tmr_value = '0;
        case (state_reg)
            S_CAL_START: state_next = S_CAL_WAIT;
            S_CAL_WAIT: begin
                if (done_rise) begin
                    state_next = S_IDLE;
                end
            end
            S_IDLE: begin
                if (go_take) begin
                    state_next = S_SYNC;
                    slot_next = '0;
                    tmr_load = 1'b1;
                    tmr_value = TW'(SYNC_CYC);
                end
            end
            S_SYNC: begin
                if (tmr_expired) begin
                    state_next = S_FIRST;
                    tmr_load = 1'b1;
                    tmr_value = TW'(ctrl_reg[`CTRL_DLY1_LO +: 4] * STEP_CYC);
                end
            end
            S_FIRST, S_GAP: begin
                if (tmr_expired) begin
                    state_next = S_CONV;
                end
            end
            S_CONV: state_next = S_WAIT;
            S_WAIT: begin
                if (done_rise && slot_reg == last_slot) begin
                    slot_next = '0;
                    if (ctrl_reg[`CTRL_CONT]) begin
                        state_next = S_LOOP;
                        tmr_load = 1'b1;
                        tmr_value = TW'(ctrl_reg[`CTRL_DLY3_LO +: 4] * STEP_CYC);
                    end else begin
                        state_next = S_IDLE;
                    end
                end else if (done_rise) begin
                    slot_next = slot_reg + 3'h1;
                    state_next = S_GAP;
                    tmr_load = 1'b1;
                    tmr_value = TW'(ctrl_reg[`CTRL_DLY2_LO +: 4] * STEP_CYC);
                end
            end
            S_LOOP: begin
                if (tmr_expired) begin
                    state_next = S_CONV;
                end
            end
            default: state_next = S_IDLE;
        endcase
        // Switching off abandons any sequence
        if (!ctrl_reg[`CTRL_ON] && state_reg != S_CAL_START && state_reg != S_CAL_WAIT) begin
            state_next = S_IDLE;
        end
    end

    // Sequencer state, slot and edge tracking
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            state_reg <= S_CAL_START;
            slot_reg <= '0;
            done_prev_reg <= 1'b0;
            calibrated_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            slot_reg <= slot_next;
            done_prev_reg <= rsp_sync.done;
            if (state_reg == S_CAL_WAIT && done_rise) begin
                calibrated_reg <= 1'b1;
            end
        end
    end

    // Result storage per slot, held while frozen in continuous mode
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            for (int i = 0; i < SLOTS; i++) begin
                result_reg[i] <= '0;
            end
        end else if (state_reg == S_WAIT && done_rise && store_ok) begin
            // Core saturates out-of-range inputs; code is stored unchanged
            result_reg[slot_reg] <= rsp_sync.code;
        end
    end

    // Requests to the core; power drops when the converter is off and not calibrating
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            core_req <= '0;
        end else begin
            core_req.power_on <= ctrl_reg[`CTRL_ON] || state_next == S_CAL_START
                                 || state_next == S_CAL_WAIT;
            core_req.calibrate <= state_reg == S_CAL_START;
            core_req.start <= state_reg == S_CONV && ctrl_reg[`CTRL_ON];
            core_req.channel <= sel_ch;
            core_req.scale <= (sel_ch == `CH_COIN_CELL) ? `SCALE_X2_3 : `SCALE_X1;
        end
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!reset_n);

    sequence s_go_taken;
        go_take ##1 state_reg == S_SYNC;
    endsequence

    a_go_self_clear: assert property (ctrl_reg[`CTRL_GO] && !wr_fire
        |=> !ctrl_reg[`CTRL_GO]) else $error("start bit did not clear");
    a_off_no_start: assert property (!ctrl_reg[`CTRL_ON] |=> !core_req.start)
        else $error("conversion started while off");
    a_sync_wait: assert property (s_go_taken |-> (state_reg == S_SYNC)[*8])
        else $error("sync wait cut short");
    a_done_flag_set: assert property (seq_end |=> done_flag_reg)
        else $error("done flag not set");
    a_mask_gates: assert property (mask_reg && $past(mask_reg) |-> !done_irq)
        else $error("masked done reached output");
    a_freeze_holds: assert property (!store_ok
        |=> $stable(result_reg[$past(slot_reg)])) else $error("result changed while frozen");
    a_slot_bound: assert property (state_reg == S_WAIT |-> slot_reg <= last_slot)
        else $error("slot beyond last slot");
    a_cal_pulse: assert property (state_reg == S_CAL_START |=> core_req.calibrate)
        else $error("calibration not requested");
    a_coin_scale: assert property (core_req.start && core_req.channel == `CH_COIN_CELL
                                   |-> core_req.scale == `SCALE_X2_3)
        else $error("coin cell channel not scaled");
    a_single_end: assert property (seq_end && !ctrl_reg[`CTRL_CONT]
        |=> state_reg == S_IDLE) else $error("single sequence did not stop");
endmodule

//--- testbench/core_model.sv
// Purpose: Behavioural converter core that answers the sequencer
// Assumes: Runs on its own link clock, unrelated in phase to sys_clk
// Notes: Code packs scale, conversion number and channel so every slot is traceable
module core_model
    import adc_seq_pkg::*;
(
    // Clocks
    input wire logic sys_clk,
    input wire logic link_clk,
    // Requests and answers
    input wire adc_seq_pkg::core_req_t core_req,
    input wire logic slow,
    output adc_seq_pkg::core_rsp_t core_rsp,
    output int conv_count
);
    timeunit 1ns;
    timeprecision 1ps;

    int reqs = 0;
    int acks = 0;
    int count = 0;
    core_req_t seen = '0;

    // The port is driven from one place only
    assign conv_count = count;

    // Request pulses last one sys_clk cycle, so catch them before the slow clock looks
    always @(posedge sys_clk) begin
        if (core_req.start || core_req.calibrate) begin
            reqs <= reqs + 1;
            seen <= core_req;
        end
        if (core_req.start) begin
            count <= count + 1;
        end
    end

    // One answer per request; slow mode stretches the conversion
    initial begin
        core_rsp = '0;
        forever begin
            @(posedge link_clk);
            if (reqs != acks) begin
                repeat (slow ? 6 : 1) @(posedge link_clk);
                core_rsp.code = {seen.scale, count[3:0], seen.channel};
                @(posedge link_clk);
                core_rsp.done = 1'b1;
                @(posedge link_clk);
                core_rsp.done = 1'b0;
                // Released code no longer shows the last value
                core_rsp.code = ~core_rsp.code;
                acks = acks + 1;
            end
        end
    end
endmodule

//--- testbench/adc_conversion_sequencer_tb.sv
// Purpose: Self-checking bench for the conversion sequencer
// Assumes: Core model on a 400 ns link clock
// Notes: Expected codes follow slot order and conversion numbering
`include "adc_seq_defines.svh"
module adc_conversion_sequencer_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import adc_seq_pkg::*;

    logic sys_clk = 1'b0;
    logic link_clk = 1'b0;
    logic reset_n = 1'b0;
    logic [7:0] awaddr = 8'h00;
    logic [7:0] araddr = 8'h00;
    logic awvalid = 1'b0;
    logic wvalid = 1'b0;
    logic arvalid = 1'b0;
    logic slow = 1'b0;
    logic bready = 1'b1;
    logic rready = 1'b1;
    logic [31:0] wdata = 32'h0;
    logic [3:0] wstrb = 4'hf;
    logic awready, wready, bvalid, arready, rvalid, core_clk_en, done_irq;
    logic [1:0] bresp, rresp, rsp;
    logic [31:0] rdata, rd, v1;
    core_req_t core_req;
    core_rsp_t core_rsp;
    int conv_count, t0, base;
    int mismatches = 0;
    int comparisons = 0;
    int cycles = 0;
    int last_en = 0;
    int seed = 75447;
    int starts[$];
    int sel[8];

    // Clocks; the link clock is offset so the two never line up
    always #25 sys_clk = ~sys_clk;
    initial #37 forever #200 link_clk = ~link_clk;

    adc_conversion_sequencer i_dut (.sys_clk(sys_clk), .reset_n(reset_n), .awaddr(awaddr),
        .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
        .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
        .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
        .rready(rready), .core_req(core_req), .core_clk_en(core_clk_en), .core_rsp(core_rsp),
        .done_irq(done_irq));

    core_model i_core (.sys_clk(sys_clk), .link_clk(link_clk), .core_req(core_req),
        .slow(slow), .core_rsp(core_rsp), .conv_count(conv_count));

    // Cycle count, start log and hang guard
    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (core_req.start) starts.push_back(cycles);
        // Slow enable must pulse at a steady pace
        if (core_clk_en) begin
            if (last_en > 0)
                check("pace", cycles - last_en, `CORE_PERIOD_NS / `CLK_PERIOD_NS);
            last_en <= cycles;
        end
        if (cycles == 40000) begin
            mismatches++;
            print_verdict();
        end
    end

    task automatic print_verdict();
        $display("Comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // Write with address and data offered together; bready stays high
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        do begin
            @(posedge sys_clk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
        end while (!bvalid);
        rsp = bresp;
    endtask

    task automatic rdr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        araddr <= a;
        arvalid <= 1'b1;
        do begin
            @(posedge sys_clk);
            if (arvalid && arready) arvalid <= 1'b0;
        end while (!rvalid);
        d = rdata;
        r = rresp;
    endtask

    function automatic logic [9:0] code_of(input int k, input int n);
        return {(sel[k] == 8) ? `SCALE_X2_3 : `SCALE_X1, 4'(n), 4'(sel[k])};
    endfunction

    // One single sequence: timing of starts, count, results, done flag
    task automatic run_seq(input logic [31:0] ctrl, input int last, input int d1, input int d2);
        logic [31:0] msk, ex;
        int lo;
        base = conv_count;
        starts.delete();
        wr(`OFF_CTRL, ctrl);
        t0 = cycles;
        wr(`OFF_CTRL, ctrl); // A go while busy must be ignored
        do rdr(`OFF_STATUS, rd, rsp); while (rd[`STAT_DONE] !== 1'b1);
        check("conversions", conv_count - base, last + 1);
        lo = starts[0] - t0 - 600 - d1 * 800;
        check("first wait", (lo >= 0) && (lo < 20), 1);
        for (int k = 1; k <= last; k++) begin
            lo = starts[k] - starts[k-1];
            check("gap", (lo >= d2 * 800) && (lo < d2 * 800 + 120), 1);
        end
        for (int p = 0; p < 4; p++) begin
            msk = {{16{2 * p + 1 <= last}}, {16{2 * p <= last}}};
            lo = base + 2 * p;
            ex = {6'h0, code_of(2 * p + 1, lo + 2), 6'h0, code_of(2 * p, lo + 1)};
            rdr(`OFF_RESULT0 + 8'(4 * p), rd, rsp);
            check("result", rd & msk, ex & msk);
        end
        rdr(`OFF_CTRL, rd, rsp);
        check("go cleared", rd[`CTRL_GO], 1'b0);
    endtask

    // Main sequence
    initial begin
        repeat (5) @(posedge sys_clk);
        reset_n <= 1'b1;
        @(posedge sys_clk);
        do rdr(`OFF_STATUS, rd, rsp); while (rd[`STAT_CAL] !== 1'b1);
        check("status", rd, 32'h0000_0004);
        rdr(`OFF_CTRL, rd, rsp);
        check("ctrl reset", rd, `CTRL_RESET);
        rdr(`OFF_SELECT, rd, rsp);
        check("select reset", rd, `SELECT_RESET);
        rdr(`OFF_MASK, rd, rsp);
        check("mask reset", rd, 32'(`MASK_RESET));
        rdr(8'h20, rd, rsp);
        check("unmapped", rsp, `RESP_SLVERR);
        wr(8'h20, 32'h0);
        check("unmapped write", rsp, `RESP_SLVERR);
        // Go without the converter on does nothing
        base = conv_count;
        wr(`OFF_CTRL, 32'h0000_0002);
        check("write resp", rsp, `RESP_OKAY);
        repeat (700) @(posedge sys_clk);
        check("off conversions", conv_count - base, 0);
        check("off power", core_req.power_on, 1'b0);
        // Random channels; slot one always takes the scaled coin cell channel
        rd = 32'h0;
        for (int k = 0; k < 8; k++) begin
            sel[k] = (k == 1) ? 8 : ($random(seed) & 15);
            rd[4*k +: 4] = 4'(sel[k]);
        end
        wr(`OFF_SELECT, rd);
        run_seq(32'h0000_1123, 2, 1, 1);
        check("irq", done_irq, 1'b1);
        wr(`OFF_STATUS, 32'h1);
        // The output follows the cleared flag one edge later
        @(posedge sys_clk);
        check("irq cleared", done_irq, 1'b0);
        // All eight slots with a slow core and the event masked
        slow <= 1'b1;
        wr(`OFF_MASK, 32'h1);
        run_seq(32'h0000_0073, 7, 0, 0);
        check("masked irq", done_irq, 1'b0);
        wr(`OFF_MASK, 32'h0);
        @(posedge sys_clk);
        check("unmasked irq", done_irq, 1'b1);
        wr(`OFF_STATUS, 32'h1);
        // Continuous loop on slot zero with a restart delay
        slow <= 1'b0;
        base = conv_count;
        starts.delete();
        wr(`OFF_CTRL, 32'h0001_0007);
        while (conv_count < base + 3) @(posedge sys_clk);
        t0 = starts[2] - starts[1];
        check("loop gap", (t0 >= 800) && (t0 < 800 + 720), 1);
        wr(`OFF_CTRL, 32'h0001_000d);
        base = conv_count;
        while (conv_count < base + 2) @(posedge sys_clk);
        rdr(`OFF_RESULT0, v1, rsp);
        while (conv_count < base + 4) @(posedge sys_clk);
        rdr(`OFF_RESULT0, rd, rsp);
        check("frozen", rd, v1);
        wr(`OFF_CTRL, 32'h0001_0005);
        while (conv_count < base + 7) @(posedge sys_clk);
        rdr(`OFF_RESULT0, rd, rsp);
        check("released", rd !== v1, 1);
        wr(`OFF_CTRL, 32'h0);
        repeat (5) @(posedge sys_clk);
        check("power off", core_req.power_on, 1'b0);
        print_verdict();
    end
endmodule
